//--- sacc_pkg.sv
// shared constants and types of the conversion control block
package sacc_pkg;

  // result and channel widths
  localparam int RES_W = 10;
  localparam int CH_W = 4;
  localparam logic [RES_W-1:0] RES_RST = 10'h000;
  localparam logic [RES_W-1:0] SAR_FIRST_TRIAL = 10'h200;
  localparam logic [3:0] TEMP_CH = 4'h8;
  localparam logic [3:0] PAIR_CFG_RST = 4'h0;

  // start-mode field encodings
  localparam logic [1:0] START_SW = 2'b00;
  localparam logic [1:0] START_T3 = 2'b01;
  localparam logic [1:0] START_EXT = 2'b10;
  localparam logic [1:0] START_T2 = 2'b11;

  // gain field encodings, one-hot select positions
  localparam logic [2:0] GAIN_X1 = 3'h0;
  localparam logic [2:0] GAIN_X2 = 3'h1;
  localparam logic [2:0] GAIN_X4 = 3'h2;
  localparam logic [2:0] GAIN_X8 = 3'h3;
  localparam logic [2:0] GAIN_X16 = 3'h4;
  localparam logic [2:0] GAIN_RST = GAIN_X1;
  localparam logic [5:0] GSEL_HALF = 6'h01;
  localparam logic [5:0] GSEL_X1 = 6'h02;
  localparam logic [5:0] GSEL_X2 = 6'h04;
  localparam logic [5:0] GSEL_X4 = 6'h08;
  localparam logic [5:0] GSEL_X8 = 6'h10;
  localparam logic [5:0] GSEL_X16 = 6'h20;

  // track length and last convert count (16 clocks) in conversion clocks
  localparam logic [3:0] TRACK_CLKS = 4'h3;
  localparam logic [3:0] CONV_CLKS = 4'hf;
  localparam logic [3:0] DIV_CNT_RST = 4'h0;

  typedef enum logic [1:0] {
    SACC_IDLE,
    SACC_TRACK,
    SACC_CONVERT
  } sacc_state_t;

endpackage

//--- sacc_clk_div.sv
// conversion clock tick generator, divide by 2, 4, 8 or 16
`timescale 1ns/100ps
module sacc_clk_div (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [1:0] scale,
  // tick out
  output logic tick
);

  logic [3:0] cnt_r;
  logic [3:0] term;

  // terminal count is the division ratio minus one
  always_comb begin
    unique case (scale)
      2'b00: term = 4'h1;
      2'b01: term = 4'h3;
      2'b10: term = 4'h7;
      2'b11: term = 4'hf;
    endcase
  end

  // restart on every run so each phase begins on a whole period
  always_ff @(posedge clk) begin
    if (rst || !run || cnt_r >= term) begin
      cnt_r <= sacc_pkg::DIV_CNT_RST;
    end else begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  assign tick = run && (cnt_r == term);

endmodule

//--- sacc_ctrl.sv
// conversion sequencing, input selection and result handling
`timescale 1ns/100ps
//
// Contract
// - converter, hold and amplifier run only while subsystem enable is one
// - mux offers eight external channels plus internal temperature sensor
// - selected gain applies equally to the temperature channel
// - each adjacent pair is single-ended or differential, changeable between conversions
// - after reset all pairs are single-ended
// - three-bit gain field selects 0.5, 1, 2, 4, 8 or 16
// - after reset gain is unity
// - conversion clock is system clock divided by 2, 4, 8 or 16
// - start mode picks software, timer 3, external edge or timer 2
// - external mode starts a conversion on convert-start rising edge
// - busy reads one during conversion and zero when complete
// - busy falling sets completion flag and interrupts if enabled; a shutdown abort drops busy without setting it
// - ten-bit result placed in byte pair, left or right justified
// - default track mode tracks continuously except during conversion
// - low-power internal trigger tracks three conversion clocks then converts
// - low-power external mode tracks only while convert-start is low
// - tracking disabled while chip is in standby or sleep
module sacc_ctrl (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // enables
  input wire logic CONV_SUBSYS_ENABLE,
  input wire logic REF_BIAS_ENABLE,
  input wire logic CHIP_STANDBY,
  // conversion configuration
  input wire logic START_MODE_HI,
  input wire logic START_MODE_LO,
  input wire logic LOW_POWER_TRACK_MODE,
  input wire logic RESULT_LEFT_JUSTIFY,
  input wire logic [1:0] CONV_CLOCK_SCALE,
  input wire logic [2:0] AMP_GAIN_FIELD,
  // input multiplexer configuration
  input wire logic [3:0] MUX_CHANNEL_SELECT,
  input wire logic [3:0] MUX_PAIR_CONFIG,
  // start sources
  input wire logic CONV_BUSY_WRITE,
  input wire logic TIMER3_OVERFLOW,
  input wire logic TIMER2_OVERFLOW,
  input wire logic EXT_CONVERT_START,
  // completion interrupt
  input wire logic EOC_INT_ENABLE,
  input wire logic EOC_FLAG_CLEAR,
  // analog macro comparator
  input wire logic SAR_COMP_IN,
  // status
  output logic CONV_BUSY,
  output logic EOC_FLAG,
  output logic EOC_IRQ,
  output logic [7:0] RESULT_HIGH_BYTE,
  output logic [7:0] RESULT_LOW_BYTE,
  // analog controls
  output logic SUBSYS_POWER_ON,
  output logic BIAS_ON,
  output logic TRACK_ENABLE,
  output logic HOLD_CONVERT,
  output logic [9:0] SAR_DAC_CODE,
  output logic [3:0] MUX_POS_CH,
  output logic [2:0] MUX_NEG_CH,
  output logic MUX_DIFF,
  output logic [5:0] AMP_GAIN_SEL
);

  sacc_pkg::sacc_state_t state_r;
  sacc_pkg::sacc_state_t state_nxt;
  logic [3:0] phase_cnt_r;
  logic [3:0] phase_cnt_nxt;
  logic [9:0] sar_r;
  logic [9:0] trial_mask_r;
  logic [9:0] result_r;
  logic busy_r;
  logic busy_nxt;
  logic eoc_flag_r;
  logic done;
  logic sar_tick;
  logic [1:0] start_mode;
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic ext_rise;
  logic trig;
  logic start_req;
  logic lp_ext_mode;
  logic track_r;
  logic hold_r;
  logic power_r;
  logic bias_r;
  logic [7:0] res_hi_r;
  logic [7:0] res_lo_r;
  logic [3:0] mux_pos_r;
  logic [2:0] mux_neg_r;
  logic mux_diff_r;
  logic [5:0] gain_sel_r;
  logic [1:0] pair_idx;

  assign start_mode = {START_MODE_HI, START_MODE_LO};
  assign lp_ext_mode = LOW_POWER_TRACK_MODE && (start_mode == sacc_pkg::START_EXT);

  // convert-start pin crosses in through two flops, edge taken after them
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else begin
      ext_meta_r <= EXT_CONVERT_START;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  assign ext_rise = ext_sync_r && !ext_prev_r;

  // trigger source selection
  always_comb begin
    unique case (start_mode)
      sacc_pkg::START_SW: trig = CONV_BUSY_WRITE;
      sacc_pkg::START_T3: trig = TIMER3_OVERFLOW;
      sacc_pkg::START_EXT: trig = ext_rise;
      sacc_pkg::START_T2: trig = TIMER2_OVERFLOW;
    endcase
  end

  // triggers while busy or in shutdown are dropped
  assign start_req = trig && CONV_SUBSYS_ENABLE && !CHIP_STANDBY
                     && (state_r == sacc_pkg::SACC_IDLE);

  // conversion clock ticks only while a phase runs
  sacc_clk_div u_div (
    .clk(SYS_CLK),
    .rst(RESET),
    .run(state_r != sacc_pkg::SACC_IDLE),
    .scale(CONV_CLOCK_SCALE),
    .tick(sar_tick)
  );

  // sequencer
  always_comb begin
    state_nxt = state_r;
    phase_cnt_nxt = phase_cnt_r;
    busy_nxt = busy_r;
    done = 1'b0;
    if (!CONV_SUBSYS_ENABLE) begin
      // shutdown aborts silently, no completion flag
      state_nxt = sacc_pkg::SACC_IDLE;
      phase_cnt_nxt = sacc_pkg::DIV_CNT_RST;
      busy_nxt = 1'b0;
    end else begin
      unique case (state_r)
        sacc_pkg::SACC_IDLE: begin
          if (start_req) begin
            busy_nxt = 1'b1;
            phase_cnt_nxt = sacc_pkg::DIV_CNT_RST;
            // low-power internal triggers track first
            if (LOW_POWER_TRACK_MODE && start_mode != sacc_pkg::START_EXT) begin
              state_nxt = sacc_pkg::SACC_TRACK;
            end else begin
              state_nxt = sacc_pkg::SACC_CONVERT;
            end
          end
        end
        sacc_pkg::SACC_TRACK: begin
          if (sar_tick) begin
            if (phase_cnt_r == sacc_pkg::TRACK_CLKS - 4'h1) begin
              state_nxt = sacc_pkg::SACC_CONVERT;
              phase_cnt_nxt = sacc_pkg::DIV_CNT_RST;
            end else begin
              phase_cnt_nxt = phase_cnt_r + 4'h1;
            end
          end
        end
        sacc_pkg::SACC_CONVERT: begin
          if (sar_tick) begin
            if (phase_cnt_r == sacc_pkg::CONV_CLKS) begin
              // last bit already stored, so busy may drop
              state_nxt = sacc_pkg::SACC_IDLE;
              phase_cnt_nxt = sacc_pkg::DIV_CNT_RST;
              busy_nxt = 1'b0;
              done = 1'b1;
            end else begin
              phase_cnt_nxt = phase_cnt_r + 4'h1;
            end
          end
        end
        default: begin
          state_nxt = sacc_pkg::SACC_IDLE;
          busy_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      state_r <= sacc_pkg::SACC_IDLE;
      phase_cnt_r <= sacc_pkg::DIV_CNT_RST;
      busy_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      phase_cnt_r <= phase_cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  // successive approximation, one bit per conversion clock
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      sar_r <= sacc_pkg::RES_RST;
      trial_mask_r <= sacc_pkg::RES_RST;
    end else if (state_r != sacc_pkg::SACC_CONVERT && state_nxt == sacc_pkg::SACC_CONVERT) begin
      sar_r <= sacc_pkg::SAR_FIRST_TRIAL;
      trial_mask_r <= sacc_pkg::SAR_FIRST_TRIAL;
    end else if (state_r == sacc_pkg::SACC_CONVERT && sar_tick && trial_mask_r != 10'h000) begin
      // comparator high keeps the trial bit, next bit tried at once
      sar_r <= (SAR_COMP_IN ? sar_r : (sar_r & ~trial_mask_r)) | (trial_mask_r >> 1);
      trial_mask_r <= trial_mask_r >> 1;
    end
  end

  // result held until the next conversion stores it, one conversion clock before completion
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      result_r <= sacc_pkg::RES_RST;
    end else if (state_r == sacc_pkg::SACC_CONVERT && sar_tick
                 && phase_cnt_r == sacc_pkg::CONV_CLKS - 4'h1) begin
      result_r <= sar_r;
    end
  end

  // justification follows the bit live, so it may be flipped after the fact
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      res_hi_r <= 8'h00;
      res_lo_r <= 8'h00;
    end else if (RESULT_LEFT_JUSTIFY) begin
      res_hi_r <= result_r[9:2];
      res_lo_r <= {result_r[1:0], 6'h00};
    end else begin
      res_hi_r <= {6'h00, result_r[9:8]};
      res_lo_r <= result_r[7:0];
    end
  end

  // completion flag: a set in the clear cycle wins
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      eoc_flag_r <= 1'b0;
    end else if (done) begin
      eoc_flag_r <= 1'b1;
    end else if (EOC_FLAG_CLEAR) begin
      eoc_flag_r <= 1'b0;
    end
  end

  // track and hold control
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      track_r <= 1'b0;
      hold_r <= 1'b0;
    end else if (!CONV_SUBSYS_ENABLE || CHIP_STANDBY) begin
      track_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      hold_r <= state_nxt == sacc_pkg::SACC_CONVERT;
      unique case (state_nxt)
        sacc_pkg::SACC_TRACK: track_r <= 1'b1;
        sacc_pkg::SACC_CONVERT: track_r <= 1'b0;
        default: begin
          if (lp_ext_mode) begin
            track_r <= !ext_sync_r;
          end else begin
            track_r <= !LOW_POWER_TRACK_MODE;
          end
        end
      endcase
    end
  end

  // power and bias only with the subsystem enabled
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      power_r <= 1'b0;
      bias_r <= 1'b0;
    end else begin
      power_r <= CONV_SUBSYS_ENABLE;
      bias_r <= CONV_SUBSYS_ENABLE && REF_BIAS_ENABLE;
    end
  end

  assign pair_idx = MUX_CHANNEL_SELECT[2:1];

  // mux follows software only between conversions
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      mux_pos_r <= 4'h0;
      mux_neg_r <= 3'h0;
      mux_diff_r <= 1'b0;
    end else if (state_nxt == sacc_pkg::SACC_IDLE) begin
      if (MUX_CHANNEL_SELECT[3]) begin
        mux_pos_r <= sacc_pkg::TEMP_CH;
        mux_neg_r <= 3'h0;
        mux_diff_r <= 1'b0;
      end else if (MUX_PAIR_CONFIG[pair_idx]) begin
        mux_pos_r <= {1'b0, pair_idx, 1'b0};
        mux_neg_r <= {pair_idx, 1'b1};
        mux_diff_r <= 1'b1;
      end else begin
        mux_pos_r <= MUX_CHANNEL_SELECT;
        mux_neg_r <= 3'h0;
        mux_diff_r <= 1'b0;
      end
    end
  end

  // gain decode after the mux, same for every channel
  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      gain_sel_r <= sacc_pkg::GSEL_X1;
    end else begin
      unique case (AMP_GAIN_FIELD)
        sacc_pkg::GAIN_X1: gain_sel_r <= sacc_pkg::GSEL_X1;
        sacc_pkg::GAIN_X2: gain_sel_r <= sacc_pkg::GSEL_X2;
        sacc_pkg::GAIN_X4: gain_sel_r <= sacc_pkg::GSEL_X4;
        sacc_pkg::GAIN_X8: gain_sel_r <= sacc_pkg::GSEL_X8;
        sacc_pkg::GAIN_X16: gain_sel_r <= sacc_pkg::GSEL_X16;
        default: gain_sel_r <= sacc_pkg::GSEL_HALF;
      endcase
    end
  end

  assign CONV_BUSY = busy_r;
  assign EOC_FLAG = eoc_flag_r;
  assign EOC_IRQ = eoc_flag_r && EOC_INT_ENABLE;
  assign RESULT_HIGH_BYTE = res_hi_r;
  assign RESULT_LOW_BYTE = res_lo_r;
  assign SUBSYS_POWER_ON = power_r;
  assign BIAS_ON = bias_r;
  assign TRACK_ENABLE = track_r;
  assign HOLD_CONVERT = hold_r;
  assign SAR_DAC_CODE = sar_r;
  assign MUX_POS_CH = mux_pos_r;
  assign MUX_NEG_CH = mux_neg_r;
  assign MUX_DIFF = mux_diff_r;
  assign AMP_GAIN_SEL = gain_sel_r;

endmodule

//--- sacc_analog_model.sv
// comparator side of the analog macro
`timescale 1ns/100ps
module sacc_analog_model (
  // analog side
  input wire logic [9:0] level,
  input wire logic bias_on,
  input wire logic [9:0] dac_code,
  // comparator out
  output logic comp
);
  // unbiased converter resolves nothing, so the result reads zero
  assign comp = bias_on ? (level >= dac_code) : 1'b0;
endmodule

//--- sacc_ctrl_sva.sv
// port assertions for the conversion control block
`timescale 1ns/100ps
module sacc_ctrl_chk (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // inputs
  input wire logic CONV_SUBSYS_ENABLE,
  input wire logic CHIP_STANDBY,
  input wire logic START_MODE_HI,
  input wire logic START_MODE_LO,
  input wire logic LOW_POWER_TRACK_MODE,
  input wire logic RESULT_LEFT_JUSTIFY,
  input wire logic [1:0] CONV_CLOCK_SCALE,
  input wire logic CONV_BUSY_WRITE,
  input wire logic EOC_INT_ENABLE,
  // outputs
  input wire logic CONV_BUSY,
  input wire logic EOC_FLAG,
  input wire logic EOC_IRQ,
  input wire logic [7:0] RESULT_HIGH_BYTE,
  input wire logic [7:0] RESULT_LOW_BYTE,
  input wire logic SUBSYS_POWER_ON,
  input wire logic TRACK_ENABLE,
  input wire logic HOLD_CONVERT,
  input wire logic MUX_DIFF,
  input wire logic [5:0] AMP_GAIN_SEL
);
  logic [8:0] cnt_r;
  logic [8:0] len;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);
  // busy cycles, judged when the flag rises
  always_ff @(posedge SYS_CLK) begin
    cnt_r <= CONV_BUSY ? cnt_r + 9'h001 : 9'h000;
  end
  // external low-power mode skips the timed track
  always_comb begin
    len = ((LOW_POWER_TRACK_MODE && {START_MODE_HI, START_MODE_LO} != 2'b10) ? 9'h013
      : 9'h010) << ({1'b0, CONV_CLOCK_SCALE} + 3'h1);
  end
  property p_off;
    !CONV_SUBSYS_ENABLE |=> !CONV_BUSY && !SUBSYS_POWER_ON && !HOLD_CONVERT && !TRACK_ENABLE;
  endproperty
  a_off: assert property (p_off) else $error("active while disabled");
  property p_sw;
    !START_MODE_HI && !START_MODE_LO && CONV_BUSY_WRITE && !CONV_BUSY
      |=> CONV_BUSY == (CONV_SUBSYS_ENABLE && !CHIP_STANDBY);
  endproperty
  a_sw: assert property (p_sw) else $error("software start wrong");
  property p_len;
    $rose(EOC_FLAG) |-> $fell(CONV_BUSY) && cnt_r == len;
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_irq;
    EOC_IRQ == (EOC_FLAG && EOC_INT_ENABLE);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");
  property p_hold;
    HOLD_CONVERT |-> !TRACK_ENABLE;
  endproperty
  a_hold: assert property (p_hold) else $error("tracking while converting");
  property p_idle;
    (CONV_SUBSYS_ENABLE && !CHIP_STANDBY && !LOW_POWER_TRACK_MODE && !CONV_BUSY)[*3]
      |-> TRACK_ENABLE;
  endproperty
  a_idle: assert property (p_idle) else $error("idle not tracking");
  property p_stby;
    CHIP_STANDBY[*2] |-> !TRACK_ENABLE;
  endproperty
  a_stby: assert property (p_stby) else $error("tracking in standby");
  property p_just;
    $stable(RESULT_LEFT_JUSTIFY)
      |-> (RESULT_LEFT_JUSTIFY ? RESULT_LOW_BYTE[5:0] : RESULT_HIGH_BYTE[7:2]) == 6'h00;
  endproperty
  a_just: assert property (p_just) else $error("justify wrong");
  property p_rst;
    $fell(RESET) |-> AMP_GAIN_SEL == sacc_pkg::GSEL_X1 && !MUX_DIFF;
  endproperty
  a_rst: assert property (p_rst) else $error("reset defaults wrong");
  property p_hot;
    $onehot(AMP_GAIN_SEL);
  endproperty
  a_hot: assert property (p_hot) else $error("gain select not one-hot");
endmodule
bind sacc_ctrl sacc_ctrl_chk i_chk (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .CONV_SUBSYS_ENABLE(CONV_SUBSYS_ENABLE), .CHIP_STANDBY(CHIP_STANDBY),
  .START_MODE_HI(START_MODE_HI), .START_MODE_LO(START_MODE_LO),
  .LOW_POWER_TRACK_MODE(LOW_POWER_TRACK_MODE), .RESULT_LEFT_JUSTIFY(RESULT_LEFT_JUSTIFY),
  .CONV_CLOCK_SCALE(CONV_CLOCK_SCALE), .CONV_BUSY_WRITE(CONV_BUSY_WRITE),
  .EOC_INT_ENABLE(EOC_INT_ENABLE), .CONV_BUSY(CONV_BUSY), .EOC_FLAG(EOC_FLAG),
  .EOC_IRQ(EOC_IRQ), .RESULT_HIGH_BYTE(RESULT_HIGH_BYTE), .RESULT_LOW_BYTE(RESULT_LOW_BYTE),
  .SUBSYS_POWER_ON(SUBSYS_POWER_ON), .TRACK_ENABLE(TRACK_ENABLE),
  .HOLD_CONVERT(HOLD_CONVERT), .MUX_DIFF(MUX_DIFF), .AMP_GAIN_SEL(AMP_GAIN_SEL));

//--- sar_adc_conversion_control_test.sv
// self-checking bench for the conversion control block
`timescale 1ns/100ps
module sar_adc_conversion_control_test;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic en, bias, stby, hi, lo, lpt, lj, wr, t3, t2, ext, ie, clr, comp;
  logic busy, flag, irq, pwr, bon, trk, hold, dif;
  logic [1:0] sc;
  logic [2:0] gf, nch;
  logic [3:0] chs, pc, pch;
  logic [5:0] gsel;
  logic [7:0] hb, lb;
  logic [9:0] lvl, dac;
  int n_errors = 0;
  int num_checks = 0;
  always #5 SYS_CLK = ~SYS_CLK;
  sacc_ctrl i_dut (.SYS_CLK(SYS_CLK), .RESET(RESET), .CONV_SUBSYS_ENABLE(en),
    .REF_BIAS_ENABLE(bias), .CHIP_STANDBY(stby), .START_MODE_HI(hi), .START_MODE_LO(lo),
    .LOW_POWER_TRACK_MODE(lpt), .RESULT_LEFT_JUSTIFY(lj), .CONV_CLOCK_SCALE(sc),
    .AMP_GAIN_FIELD(gf), .MUX_CHANNEL_SELECT(chs), .MUX_PAIR_CONFIG(pc),
    .CONV_BUSY_WRITE(wr), .TIMER3_OVERFLOW(t3), .TIMER2_OVERFLOW(t2),
    .EXT_CONVERT_START(ext), .EOC_INT_ENABLE(ie), .EOC_FLAG_CLEAR(clr), .SAR_COMP_IN(comp),
    .CONV_BUSY(busy), .EOC_FLAG(flag), .EOC_IRQ(irq), .RESULT_HIGH_BYTE(hb),
    .RESULT_LOW_BYTE(lb), .SUBSYS_POWER_ON(pwr), .BIAS_ON(bon), .TRACK_ENABLE(trk),
    .HOLD_CONVERT(hold), .SAR_DAC_CODE(dac), .MUX_POS_CH(pch), .MUX_NEG_CH(nch),
    .MUX_DIFF(dif), .AMP_GAIN_SEL(gsel));
  sacc_analog_model i_ana (.level(lvl), .bias_on(bon), .dac_code(dac), .comp(comp));
  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // one trigger, then busy length, flag, irq and track level after
  task automatic conv(input int src, input int len);
    int n;
    n = 0;
    case (src)
      0: wr = 1'b1;
      1: t3 = 1'b1;
      2: ext = 1'b1;
      default: t2 = 1'b1;
    endcase
    cyc(1);
    {wr, t3, t2} = 3'b000;
    while (busy !== 1'b1 && n < 8) begin
      cyc(1);
      n++;
    end
    if (n == 8) begin
      n_errors++;
      $display("ERROR start expected 1 seen %b", busy);
      end_sim;
    end
    n = 0;
    while (busy === 1'b1 && n < 700) begin
      n++;
      cyc(1);
    end
    chk("busy_len", 16'(len), 16'(n));
    chk("flag", 16'h1, {15'h0, flag});
    chk("irq", {15'h0, ie}, {15'h0, irq});
    chk("track", {15'h0, !lpt}, {15'h0, trk});
    ext = 1'b0;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(1);
    chk("flag_clr", 16'h0, {15'h0, flag});
  endtask
  task automatic t_reset;
    chk("gain_rst", 16'h2, {10'h0, gsel});
    chk("diff_rst", 16'h0, {15'h0, dif});
    chk("busy_rst", 16'h0, {15'h0, busy});
    $display("reset test done");
  endtask
  task automatic t_mux;
    pc = 4'h2;
    chs = 4'h2;
    cyc(3);
    chk("pair", 16'h0123, {7'h0, dif, pch, 1'b0, nch});
    chs = 4'h8;
    cyc(3);
    chk("temp", 16'h8, {11'h0, dif, pch});
    pc = 4'h0;
    chs = 4'h2;
    cyc(3);
    chk("single", 16'h2, {11'h0, dif, pch});
    chs = 4'h8;
    $display("mux test done");
  endtask
  task automatic t_gain;
    for (int g = 0; g < 8; g++) begin
      gf = 3'(g);
      cyc(3);
      chk("gain", (g < 5) ? 16'h2 << g : 16'h1, {10'h0, gsel});
    end
    gf = sacc_pkg::GAIN_RST;
    $display("gain test done");
  endtask
  // every start mode and scale, wrong sources ignored
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      {hi, lo} = 2'(m);
      sc = 2'(m);
      ie = m[0];
      lvl = 10'h2b1 + 10'(m);
      {wr, t3, t2} = {m != 0, m != 1, m != 3};
      cyc(1);
      {wr, t3, t2} = 3'b000;
      cyc(4);
      chk("ignored", 16'h0, {15'h0, busy});
      conv(m, 32 << m);
      chk("right", {6'h0, lvl}, {hb, lb});
      lj = 1'b1;
      cyc(2);
      chk("left", {lvl, 6'h0}, {hb, lb});
      lj = 1'b0;
      cyc(2);
    end
    $display("mode test done");
  endtask
  task automatic t_lowpower;
    {hi, lo, sc} = 4'h0;
    lpt = 1'b1;
    cyc(3);
    chk("lp_idle", 16'h0, {15'h0, trk});
    conv(0, 38);
    {hi, lo} = 2'b10;
    cyc(5);
    chk("lp_ext_low", 16'h1, {15'h0, trk});
    conv(2, 32);
    lpt = 1'b0;
    {hi, lo} = 2'b00;
    $display("low power test done");
  endtask
  task automatic t_refuse;
    stby = 1'b1;
    cyc(3);
    chk("stby_trk", 16'h0, {15'h0, trk});
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(3);
    chk("stby_busy", 16'h0, {15'h0, busy});
    stby = 1'b0;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(5);
    chk("started", 16'h1, {15'h0, busy});
    en = 1'b0;
    cyc(3);
    chk("abort", 16'h0, {11'h0, bon, busy, flag, pwr, hold});
    en = 1'b1;
    cyc(3);
    chk("power", 16'h3, {14'h0, pwr, bon});
    bias = 1'b0;
    cyc(2);
    chk("bias_off", 16'h2, {14'h0, pwr, bon});
    bias = 1'b1;
    $display("refuse test done");
  endtask
  initial begin
    {en, bias, stby, hi, lo, lpt, lj, wr, t3, t2, ext, ie, clr} = 13'h0;
    {sc, gf, chs, pc, lvl} = 23'h0;
    cyc(20);
    RESET = 1'b0;
    en = 1'b1;
    bias = 1'b1;
    cyc(3);
    t_reset;
    t_mux;
    t_gain;
    t_modes;
    t_lowpower;
    t_refuse;
    end_sim;
  end
endmodule
